// ==== core/dbc_core.sv ====
// Debug control and status: control word, two breakpoint units, status word.
// Assumes TAP-side pins change around TCK and are stable at the TCK rise in update-DR.
`timescale 1ns/100ps
module dbc_core
  import dbc_pkg::*;
(
  // Clock, reset, enable.
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_ce,
  // TAP side pins.
  input wire logic i_tck,
  input wire logic i_test_logic_reset,
  input wire logic i_update_dr,
  input wire logic [4:0] i_cmd_rs,
  input wire logic i_cmd_go,
  input wire logic i_cmd_exit,
  input wire logic i_cmd_read,
  input wire logic [31:0] i_dr_data,
  input wire logic i_debug_enable_pin_n,
  // CPU side.
  input wire logic i_internal_debug_request_in_n,
  input wire logic i_acc_valid,
  input wire logic [31:0] i_acc_addr,
  input wire logic i_acc_instr,
  input wire logic i_acc_cof,
  input wire logic i_acc_write,
  input wire logic i_acc_super,
  input wire logic [31:0] i_base_a,
  input wire logic [31:0] i_mask_a,
  input wire logic [31:0] i_base_b,
  input wire logic [31:0] i_mask_b,
  input wire logic i_trace_zero,
  input wire logic i_sw_bkpt,
  input wire logic i_cpu_debug_entry,
  input wire logic i_cpu_in_debug,
  input wire logic i_cpu_low_power,
  // Outputs.
  output logic o_debug_request,
  output logic o_breakpoint_request_out,
  output logic o_exit_debug,
  output logic o_fifo_freeze,
  output logic o_trace_count_enable,
  output logic [31:0] o_control_word,
  output logic [15:0] o_debug_entry_status
);

  logic [DBC_SYNC_W-1:0] sync1_reg;
  logic [DBC_SYNC_W-1:0] sync2_reg;
  logic tck_d_reg;
  logic [31:0] ctrl_reg;
  logic [7:0] occ_reg;
  logic [31:0] latched_access_address;
  logic lat_valid_reg, lat_instr_reg, lat_cof_reg, lat_write_reg, lat_super_reg;
  logic hw_pend_reg, mb_pend_reg, tz_pend_reg, sw_pend_reg;
  logic brk_reg, exit_reg;
  logic [1:0] pm_reg;

  logic tck_s, tlr_s, upd_s, go_s, ex_s, rd_s, de_n_s;
  logic [4:0] rs_s;
  logic [31:0] data_s;
  logic update_edge, exit_cmd, ctrl_write;
  logic [4:0] access_control_a, access_control_b;
  logic range_select_a, range_select_b, freeze_select, trace_enable;
  logic internal_request_enable, force_debug_request;
  logic [1:0] sequential_control;
  logic hit_a, hit_b, b_eff, freeze_evt, arm_a, arm_b, hw_req;
  logic [7:0] occ_next;

  // Qualifies one access against a five-bit access-control code.
  function automatic logic acc_qual(input logic [4:0] bc, input logic instr, input logic cof,
                                    input logic wr, input logic sup);
    logic priv_ok;
    logic type_ok;
    priv_ok = 1'b0;
    type_ok = 1'b0;
    case (bc[4:3])
      2'b00: priv_ok = 1'b1;
      2'b10: priv_ok = !sup;
      2'b11: priv_ok = sup;
      default: priv_ok = 1'b0;
    endcase
    case (bc[2:0])
      3'h1: type_ok = 1'b1;
      3'h2: type_ok = instr;
      3'h3: type_ok = !instr;
      3'h4: type_ok = instr && cof;
      3'h5: type_ok = !instr && wr;
      3'h6: type_ok = !instr && !wr;
      default: type_ok = 1'b0;
    endcase
    return priv_ok && type_ok;
  endfunction : acc_qual

  // Two-flop synchronisers for everything coming from the TAP side.
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      sync1_reg <= DBC_SYNC_RESET;
      sync2_reg <= DBC_SYNC_RESET;
    end else if (i_ce) begin
      sync1_reg <= {i_tck, i_test_logic_reset, i_update_dr, i_cmd_go, i_cmd_exit, i_cmd_read,
                    i_debug_enable_pin_n, i_cmd_rs, i_dr_data};
      sync2_reg <= sync1_reg;
    end
  end

  assign {tck_s, tlr_s, upd_s, go_s, ex_s, rd_s, de_n_s, rs_s, data_s} = sync2_reg;

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      tck_d_reg <= 1'b0;
    end else if (i_ce) begin
      tck_d_reg <= tck_s;
    end
  end

  assign update_edge = tck_s && !tck_d_reg && upd_s && !tlr_s;
  assign exit_cmd = update_edge && go_s && ex_s &&
                    (rs_s == DBC_RS_CPUSCR || rs_s == DBC_RS_BYPASS);
  assign ctrl_write = update_edge && !rd_s && rs_s == DBC_RS_CONTROL;

  // Control word, loaded by a write command at update-DR.
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      ctrl_reg <= DBC_CW_RESET;
    end else if (i_ce) begin
      if (tlr_s) begin
        ctrl_reg <= DBC_CW_RESET;
      end else if (ctrl_write) begin
        ctrl_reg <= data_s;
      end
    end
  end

  assign access_control_a = ctrl_reg[DBC_CW_ACA_LSB +: 5];
  assign access_control_b = ctrl_reg[DBC_CW_ACB_LSB +: 5];
  assign range_select_a = ctrl_reg[DBC_CW_RSA];
  assign range_select_b = ctrl_reg[DBC_CW_RSB];
  assign freeze_select = ctrl_reg[DBC_CW_FRZ];
  assign trace_enable = ctrl_reg[DBC_CW_TME];
  assign internal_request_enable = ctrl_reg[DBC_CW_IRE];
  assign force_debug_request = ctrl_reg[DBC_CW_FDR];
  assign sequential_control = ctrl_reg[DBC_CW_SQC_LSB +: 2];

  // Memory address latch and access attributes, taken on every access.
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      latched_access_address <= 32'h0000_0000;
      lat_valid_reg <= 1'b0;
      lat_instr_reg <= 1'b0;
      lat_cof_reg <= 1'b0;
      lat_write_reg <= 1'b0;
      lat_super_reg <= 1'b0;
    end else if (i_ce) begin
      lat_valid_reg <= i_acc_valid;
      if (i_acc_valid) begin
        latched_access_address <= i_acc_addr;
        lat_instr_reg <= i_acc_instr;
        lat_cof_reg <= i_acc_cof;
        lat_write_reg <= i_acc_write;
        lat_super_reg <= i_acc_super;
      end
    end
  end

  // Comparators with range sense and access qualification.
  assign hit_a = lat_valid_reg && access_control_a != 5'h00 &&
                 (((latched_access_address & i_mask_a) == (i_base_a & i_mask_a))
                  ^ range_select_a) &&
                 acc_qual(access_control_a, lat_instr_reg, lat_cof_reg, lat_write_reg,
                          lat_super_reg);
  assign hit_b = lat_valid_reg && access_control_b != 5'h00 &&
                 (((latched_access_address & i_mask_b) == (i_base_b & i_mask_b))
                  ^ range_select_b) &&
                 acc_qual(access_control_b, lat_instr_reg, lat_cof_reg, lat_write_reg,
                          lat_super_reg);

  // Sequencing: A may arm B, B may arm trace.
  assign b_eff = hit_b && (!sequential_control[1] || occ_reg[DBC_ST_SQA-2]);
  assign arm_a = sequential_control[1] && hit_a;
  assign arm_b = sequential_control[0] && b_eff;
  assign freeze_evt = b_eff && freeze_select && !sequential_control[0];
  assign hw_req = !de_n_s || (internal_request_enable && !i_internal_debug_request_in_n);

  // Breakpoint request to the CPU, registered.
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      brk_reg <= 1'b0;
    end else if (i_ce) begin
      brk_reg <= (hit_a && !sequential_control[1]) ||
                 (b_eff && !sequential_control[0] && !freeze_select);
    end
  end

  // Causes seen since the last exit, folded into status at debug entry.
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      hw_pend_reg <= 1'b0;
      mb_pend_reg <= 1'b0;
      tz_pend_reg <= 1'b0;
      sw_pend_reg <= 1'b0;
    end else if (i_ce) begin
      if (tlr_s || (exit_cmd && !hw_req)) begin
        hw_pend_reg <= 1'b0;
      end else if (hw_req) begin
        hw_pend_reg <= 1'b1;
      end
      if (tlr_s || (exit_cmd && !brk_reg)) begin
        mb_pend_reg <= 1'b0;
      end else if (brk_reg) begin
        mb_pend_reg <= 1'b1;
      end
      if (tlr_s || (exit_cmd && !(i_trace_zero && o_trace_count_enable))) begin
        tz_pend_reg <= 1'b0;
      end else if (i_trace_zero && o_trace_count_enable) begin
        tz_pend_reg <= 1'b1;
      end
      if (tlr_s || (exit_cmd && !i_sw_bkpt)) begin
        sw_pend_reg <= 1'b0;
      end else if (i_sw_bkpt) begin
        sw_pend_reg <= 1'b1;
      end
    end
  end

  // Occurrence bits: set wins over the exit clear in the same cycle.
  always_comb begin
    occ_next = occ_reg;
    if (exit_cmd) begin
      occ_next = DBC_OCC_RESET;
    end
    if (i_cpu_debug_entry) begin
      if (hw_pend_reg || hw_req) occ_next[DBC_ST_HW_REQUEST_OCCURRED-2] = 1'b1;
      if (force_debug_request) occ_next[DBC_ST_DRO-2] = 1'b1;
      if (mb_pend_reg || brk_reg) occ_next[DBC_ST_MBO-2] = 1'b1;
      if (sw_pend_reg || i_sw_bkpt) occ_next[DBC_ST_SWO-2] = 1'b1;
      if (tz_pend_reg) occ_next[DBC_ST_TO-2] = 1'b1;
    end
    if (freeze_evt) occ_next[DBC_ST_FREEZE_OCCURRED-2] = 1'b1;
    if (arm_b) occ_next[DBC_ST_SQB-2] = 1'b1;
    if (arm_a) occ_next[DBC_ST_SQA-2] = 1'b1;
  end

  // Occurrence register and processor mode capture.
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      occ_reg <= DBC_OCC_RESET;
    end else if (i_ce) begin
      if (tlr_s) begin
        occ_reg <= DBC_OCC_RESET;
      end else begin
        occ_reg <= occ_next;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      pm_reg <= DBC_PM_NORMAL;
    end else if (i_ce) begin
      if (i_cpu_in_debug) begin
        pm_reg <= DBC_PM_DEBUG;
      end else if (i_cpu_low_power) begin
        pm_reg <= DBC_PM_LOWPWR;
      end else begin
        pm_reg <= DBC_PM_NORMAL;
      end
    end
  end

  // Exit pulse to the CPU.
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      exit_reg <= 1'b0;
    end else if (i_ce) begin
      exit_reg <= exit_cmd;
    end
  end

  // A held force bit keeps the request up, so the CPU comes straight back after exit.
  assign o_debug_request = force_debug_request || hw_req;
  assign o_breakpoint_request_out = brk_reg;
  assign o_exit_debug = exit_reg;
  assign o_fifo_freeze = occ_reg[DBC_ST_FREEZE_OCCURRED-2];
  assign o_trace_count_enable = trace_enable &&
                                (!sequential_control[0] || occ_reg[DBC_ST_SQB-2]);
  assign o_control_word = ctrl_reg;
  assign o_debug_entry_status = {6'h00, occ_reg, pm_reg};

endmodule : dbc_core

// ==== core/dbc_pkg.sv ====
// Constants of the debug breakpoint control and status block.
// Assumes a TAP controller outside that presents command fields and TCK as pins.
package dbc_pkg;
  // Register select codes of the command word.
  localparam logic [4:0] DBC_RS_CPUSCR = 5'h0B;
  localparam logic [4:0] DBC_RS_BYPASS = 5'h0C;
  localparam logic [4:0] DBC_RS_CONTROL = 5'h0D;
  localparam logic [4:0] DBC_RS_BYPASS_ALT = 5'h1F;
  // Field positions of the control word.
  localparam int DBC_CW_ACA_LSB = 0;
  localparam int DBC_CW_ACB_LSB = 5;
  localparam int DBC_CW_RSA = 10;
  localparam int DBC_CW_RSB = 11;
  localparam int DBC_CW_FRZ = 12;
  localparam int DBC_CW_TME = 13;
  localparam int DBC_CW_IRE = 14;
  localparam int DBC_CW_FDR = 15;
  localparam int DBC_CW_SQC_LSB = 16;
  // Bit positions of the status word.
  localparam int DBC_ST_HW_REQUEST_OCCURRED = 9;
  localparam int DBC_ST_DRO = 8;
  localparam int DBC_ST_MBO = 7;
  localparam int DBC_ST_SWO = 6;
  localparam int DBC_ST_TO = 5;
  localparam int DBC_ST_FREEZE_OCCURRED = 4;
  localparam int DBC_ST_SQB = 3;
  localparam int DBC_ST_SQA = 2;
  // Reset values.
  localparam logic [31:0] DBC_CW_RESET = 32'h0000_0000;
  localparam logic [7:0] DBC_OCC_RESET = 8'h00;
  // Processor mode codes.
  localparam logic [1:0] DBC_PM_NORMAL = 2'h0;
  localparam logic [1:0] DBC_PM_LOWPWR = 2'h1;
  localparam logic [1:0] DBC_PM_DEBUG = 2'h2;
  // Width of the synchronised TAP-side bundle.
  localparam int DBC_SYNC_W = 44;
  // Idle levels of the synchronised bundle: only the active-low debug-enable pin sits high.
  localparam logic [DBC_SYNC_W-1:0] DBC_SYNC_RESET = 44'h020_0000_0000;
endpackage : dbc_pkg

// ==== test/dbc_core_test.sv ====
// Self-checking testbench of the debug control and status block.
// Assumes the command controller model drives the TAP-side pins.
`timescale 1ns/100ps
module dbc_core_test;
  import dbc_pkg::*;
  logic i_clk, i_sys_rst, i_ce, i_tck, i_test_logic_reset, i_update_dr, i_cmd_go, i_cmd_exit;
  logic i_cmd_read, i_debug_enable_pin_n, i_internal_debug_request_in_n, i_acc_valid;
  logic i_acc_instr, i_acc_cof, i_acc_write, i_acc_super, i_trace_zero, i_sw_bkpt;
  logic i_cpu_debug_entry, i_cpu_in_debug, i_cpu_low_power, o_debug_request;
  logic o_breakpoint_request_out, o_exit_debug, o_fifo_freeze, o_trace_count_enable;
  logic [4:0] i_cmd_rs;
  logic [31:0] i_dr_data, i_acc_addr, i_base_a, i_mask_a, i_base_b, i_mask_b, o_control_word;
  logic [15:0] o_debug_entry_status;
  logic [2:0] ger;
  int miscompares = 0;
  int compares = 0;
  `define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin miscompares++; \
    $display("[FAIL] %0t got %0h exp %0h", $time, got, exp); end end
  dbc_core DUT (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_ce(i_ce),
    .i_tck(i_tck),
    .i_test_logic_reset(i_test_logic_reset),
    .i_update_dr(i_update_dr),
    .i_cmd_rs(i_cmd_rs),
    .i_cmd_go(i_cmd_go),
    .i_cmd_exit(i_cmd_exit),
    .i_cmd_read(i_cmd_read),
    .i_dr_data(i_dr_data),
    .i_debug_enable_pin_n(i_debug_enable_pin_n),
    .i_internal_debug_request_in_n(i_internal_debug_request_in_n),
    .i_acc_valid(i_acc_valid),
    .i_acc_addr(i_acc_addr),
    .i_acc_instr(i_acc_instr),
    .i_acc_cof(i_acc_cof),
    .i_acc_write(i_acc_write),
    .i_acc_super(i_acc_super),
    .i_base_a(i_base_a),
    .i_mask_a(i_mask_a),
    .i_base_b(i_base_b),
    .i_mask_b(i_mask_b),
    .i_trace_zero(i_trace_zero),
    .i_sw_bkpt(i_sw_bkpt),
    .i_cpu_debug_entry(i_cpu_debug_entry),
    .i_cpu_in_debug(i_cpu_in_debug),
    .i_cpu_low_power(i_cpu_low_power),
    .o_debug_request(o_debug_request),
    .o_breakpoint_request_out(o_breakpoint_request_out),
    .o_exit_debug(o_exit_debug),
    .o_fifo_freeze(o_fifo_freeze),
    .o_trace_count_enable(o_trace_count_enable),
    .o_control_word(o_control_word),
    .o_debug_entry_status(o_debug_entry_status)
  );
  dbc_host u_host (.o_tck(i_tck), .o_tlr(i_test_logic_reset), .o_upd(i_update_dr),
    .o_rs(i_cmd_rs), .o_ger(ger), .o_data(i_dr_data));
  assign {i_cmd_go, i_cmd_exit, i_cmd_read} = ger;
  initial begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask : tick
  task automatic wcw(input logic [31:0] d);
    u_host.cmd(DBC_RS_CONTROL, 3'h0, d);
    tick(3);
  endtask : wcw
  task automatic exitc(input logic [4:0] rs);
    i_cpu_in_debug = 1'b0;
    u_host.cmd(rs, 3'h6, 32'h0);
    tick(3);
  endtask : exitc
  task automatic enter;
    {i_cpu_debug_entry, i_cpu_in_debug} = 2'h3;
    tick(1);
    i_cpu_debug_entry = 1'b0;
    tick(2);
  endtask : enter
  task automatic acc(input logic [31:0] a, input logic [3:0] attr, input logic exp);
    {i_acc_addr, i_acc_instr, i_acc_cof, i_acc_write, i_acc_super, i_acc_valid} = {a, attr, 1'b1};
    tick(1);
    i_acc_valid = 1'b0;
    tick(1);
    `CHK(o_breakpoint_request_out, exp)
  endtask : acc
  task automatic summarize;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : summarize
  initial begin
    #200us;
    miscompares++;
    summarize();
  end
  initial begin
    {i_sys_rst, i_ce, i_debug_enable_pin_n, i_internal_debug_request_in_n} = 4'hF;
    {i_acc_valid, i_acc_instr, i_acc_cof, i_acc_write, i_acc_super, i_trace_zero} = 6'h00;
    {i_sw_bkpt, i_cpu_debug_entry, i_cpu_in_debug, i_cpu_low_power} = 4'h0;
    {i_acc_addr, i_base_a, i_base_b} = {32'h0, 32'h1000_0000, 32'h1000_0000};
    {i_mask_a, i_mask_b} = {32'hFFFF_FF00, 32'hFFFF_FF00};
    tick(16);
    i_sys_rst = 1'b0;
    tick(3);
    `CHK(o_debug_entry_status, 16'h0000)
    `CHK(o_control_word, DBC_CW_RESET)
    i_cpu_low_power = 1'b1;
    tick(2);
    `CHK(o_debug_entry_status[1:0], DBC_PM_LOWPWR)
    i_cpu_low_power = 1'b0;
    wcw(32'h0000_8000);
    `CHK(o_debug_request, 1'b1)
    enter();
    `CHK(o_debug_entry_status, 16'h0102)
    exitc(DBC_RS_CPUSCR);
    `CHK(o_debug_request, 1'b1)
    `CHK(o_debug_entry_status[9:2], 8'h00)
    enter();
    exitc(DBC_RS_BYPASS_ALT);
    `CHK(o_debug_entry_status[DBC_ST_DRO], 1'b1)
    exitc(DBC_RS_BYPASS);
    wcw(32'h0000_0000);
    i_internal_debug_request_in_n = 1'b0;
    tick(1);
    `CHK(o_debug_request, 1'b0)
    wcw(32'h0000_4000);
    `CHK(o_debug_request, 1'b1)
    enter();
    i_internal_debug_request_in_n = 1'b1;
    `CHK(o_debug_entry_status[DBC_ST_HW_REQUEST_OCCURRED], 1'b1)
    exitc(DBC_RS_BYPASS);
    wcw(32'h0000_0001);
    i_debug_enable_pin_n = 1'b0;
    tick(3);
    `CHK(o_debug_request, 1'b1)
    enter();
    i_debug_enable_pin_n = 1'b1;
    `CHK(o_debug_entry_status[DBC_ST_HW_REQUEST_OCCURRED], 1'b1)
    exitc(DBC_RS_BYPASS);
    acc(32'h1000_0010, 4'h0, 1'b1);
    acc(32'h2000_0000, 4'h0, 1'b0);
    wcw(32'h0000_0401);
    acc(32'h1000_0010, 4'h0, 1'b0);
    acc(32'h2000_0000, 4'h0, 1'b1);
    for (int c = 0; c < 32; c++) begin
      wcw({27'h0, c[4:0]});
      acc(32'h1000_0020, 4'h0, ((8'h4A >> c[2:0]) & 8'h01) != 8'h00 &&
          (c[4:3] == 2'h0 || c[4:3] == 2'h2));
      acc(32'h1000_0020, 4'hD, ((8'h16 >> c[2:0]) & 8'h01) != 8'h00 &&
          (c[4:3] == 2'h0 || c[4:3] == 2'h3));
    end
    exitc(DBC_RS_BYPASS);
    wcw(32'h0000_1020);
    acc(32'h1000_0030, 4'h0, 1'b0);
    tick(5);
    `CHK({o_fifo_freeze, o_debug_entry_status[DBC_ST_FREEZE_OCCURRED]}, 2'h3)
    exitc(DBC_RS_CPUSCR);
    `CHK(o_fifo_freeze, 1'b0)
    wcw(32'h0000_0020);
    acc(32'h1000_0030, 4'h0, 1'b1);
    exitc(DBC_RS_CPUSCR);
    wcw(32'h0002_0021);
    acc(32'h1000_0050, 4'h0, 1'b0);
    acc(32'h1000_0050, 4'h0, 1'b1);
    `CHK(o_debug_entry_status[DBC_ST_SQA], 1'b1)
    exitc(DBC_RS_CPUSCR);
    wcw(32'h0003_2021);
    `CHK(o_trace_count_enable, 1'b0)
    acc(32'h1000_0050, 4'h0, 1'b0);
    acc(32'h1000_0050, 4'h0, 1'b0);
    `CHK({o_trace_count_enable, o_debug_entry_status[3:2]}, 3'h7)
    exitc(DBC_RS_CPUSCR);
    wcw(32'h0000_2001);
    acc(32'h1000_0040, 4'h0, 1'b1);
    {i_trace_zero, i_sw_bkpt} = 2'h3;
    tick(1);
    {i_trace_zero, i_sw_bkpt} = 2'h0;
    enter();
    `CHK(o_debug_entry_status[9:2], 8'h38)
    u_host.tap_reset();
    tick(3);
    `CHK({o_control_word, o_debug_entry_status[9:2]}, 40'h0)
    summarize();
  end
endmodule : dbc_core_test

// ==== test/dbc_host.sv ====
// Model of the external debug command controller on the TAP-side pins.
// Assumes the TAP state is given as levels; TCK stands low between commands.
`timescale 1ns/100ps
module dbc_host (
  // TAP pins.
  output logic o_tck,
  output logic o_tlr,
  output logic o_upd,
  output logic [4:0] o_rs,
  output logic [2:0] o_ger,
  output logic [31:0] o_data
);
  initial begin
    {o_tck, o_tlr, o_upd, o_rs, o_ger, o_data} = 43'h0;
  end
  // One command: go, exit, read bits in o_ger; data held over the TCK rise.
  task automatic cmd(input logic [4:0] rs, input logic [2:0] ger, input logic [31:0] d);
    {o_rs, o_ger, o_data, o_upd} = {rs, ger, d, 1'b1};
    #80 o_tck = 1'b1;
    #80 o_tck = 1'b0;
    o_upd = 1'b0;
    o_data = ~d;
  endtask : cmd
  task automatic tap_reset;
    o_tlr = 1'b1;
    #320 o_tlr = 1'b0;
  endtask : tap_reset
endmodule : dbc_host

// ==== test/dbc_props.sv ====
// Checker of the debug control and status block, bound to its top module.
// Assumes one clock domain with a synchronous active-high reset.
`timescale 1ns/100ps
module dbc_props
  import dbc_pkg::*;
(
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // Watched inputs.
  input wire logic i_test_logic_reset,
  input wire logic i_debug_enable_pin_n,
  input wire logic i_acc_valid,
  input wire logic i_cpu_debug_entry,
  input wire logic i_cpu_in_debug,
  input wire logic i_cpu_low_power,
  // Watched outputs.
  input wire logic o_debug_request,
  input wire logic o_breakpoint_request_out,
  input wire logic o_exit_debug,
  input wire logic o_fifo_freeze,
  input wire logic [31:0] o_control_word,
  input wire logic [15:0] o_debug_entry_status
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  chk_force_request: assert property (o_control_word[DBC_CW_FDR] |-> o_debug_request)
    else $error("force bit set without debug request");
  chk_request_gate: assert property (!o_control_word[DBC_CW_IRE] &&
    !o_control_word[DBC_CW_FDR] && $past(i_debug_enable_pin_n, 2) |-> !o_debug_request)
    else $error("debug request without a cause");
  chk_tlr_clears: assert property (i_test_logic_reset [*4] |->
    o_control_word == DBC_CW_RESET && o_debug_entry_status[9:2] == 8'h00)
    else $error("test logic reset did not clear");
  chk_freeze_holds: assert property (disable iff (i_sys_rst || i_test_logic_reset)
    $fell(o_fifo_freeze) |-> o_exit_debug || $past(o_exit_debug))
    else $error("freeze dropped without exit");
  chk_status_upper_zero: assert property (o_debug_entry_status[15:10] == 6'h00)
    else $error("status upper bits not zero");
  chk_force_entry: assert property (i_cpu_debug_entry && o_control_word[DBC_CW_FDR]
    |=> o_debug_entry_status[DBC_ST_DRO])
    else $error("forced entry not recorded");
  chk_freeze_bit: assert property (o_fifo_freeze == o_debug_entry_status[DBC_ST_FREEZE_OCCURRED])
    else $error("freeze output differs from status");
  chk_exit_clears: assert property (o_exit_debug |=> o_debug_entry_status[9:2] == 8'h00)
    else $error("exit did not clear occurrences");
  chk_mode_field: assert property (o_debug_entry_status[1:0] ==
    ($past(i_cpu_in_debug) ? DBC_PM_DEBUG : {1'b0, $past(i_cpu_low_power)}))
    else $error("mode field wrong");
  chk_exit_one_cycle: assert property (o_exit_debug |=> !o_exit_debug)
    else $error("exit pulse too long");
  chk_brk_after_access: assert property (o_breakpoint_request_out |-> $past(i_acc_valid, 2))
    else $error("breakpoint request without access");
  cov_exit: cover property (o_exit_debug);
  cov_brk: cover property (o_breakpoint_request_out);
  cov_freeze: cover property ($rose(o_fifo_freeze));
endmodule : dbc_props
bind dbc_core dbc_props u_props (
  .i_clk(i_clk),
  .i_sys_rst(i_sys_rst),
  .i_test_logic_reset(i_test_logic_reset),
  .i_debug_enable_pin_n(i_debug_enable_pin_n),
  .i_acc_valid(i_acc_valid),
  .i_cpu_debug_entry(i_cpu_debug_entry),
  .i_cpu_in_debug(i_cpu_in_debug),
  .i_cpu_low_power(i_cpu_low_power),
  .o_debug_request(o_debug_request),
  .o_breakpoint_request_out(o_breakpoint_request_out),
  .o_exit_debug(o_exit_debug),
  .o_fifo_freeze(o_fifo_freeze),
  .o_control_word(o_control_word),
  .o_debug_entry_status(o_debug_entry_status)
);
